// File: verilog/gpio_regs.svh
// Register map, field positions and reset values of the general purpose I/O port bank.
// Behaviour
// - A direction bit of one makes the pin an input with its driver released.
// - A direction bit of zero drives the pin with the matching output latch bit.
// - Reading the pin level register returns the live pin levels, not the latch, save port G bits 7:5, which read the D/E/J pull-up bits.
// - Writing the pin level register address writes the output latch.
// - Reading the output latch register returns the stored latch value.
// - An enabled peripheral takes the pin over from the general purpose logic.
// - Nine ports, each with direction, pin level and output latch registers.
// - Ports B, D, E and J offer weak pull-ups on every pin.
// - One pull-up bit per port: B at control bit 7, D/E/J at port G bits 7:5.
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH

`define NUM_PORTS 9
`define PORT_WIDTH 8
`define PIN_COUNT 72
`define ADDR_WIDTH 8
`define REGS_PER_PORT 6'h03
`define PORT_REG_COUNT 6'h1b
`define SEL_DIRECTION 6'h00
`define SEL_LEVEL 6'h01
`define SEL_LATCH 6'h02
`define INTERRUPT_CONTROL_TWO_INDEX 6'h1b
`define PULLUP_B_BIT 7
`define PULLUP_D_BIT 7
`define PULLUP_E_BIT 6
`define PULLUP_J_BIT 5
`define PORT_G_INDEX 4'h6
`define DIRECTION_RESET 8'hff
`define LATCH_RESET 8'h00

`endif

// File: verilog/gpio_pkg.sv
// Types shared by the general purpose I/O port bank.
package gpio_pkg;

	typedef enum {
		REG_DIRECTION,
		REG_LEVEL,
		REG_LATCH,
		REG_PULLUP,
		REG_NONE
	} reg_kind_e;

	typedef logic [7:0] port_byte_t;

endpackage

// File: verilog/gpio_pin_slice.sv
// Pad control for one eight-pin port: driver, output enable and weak pull-up.
`timescale 1ns/10ps
`include "gpio_regs.svh"

module gpio_pin_slice
	import gpio_pkg::*;
#(
	parameter bit HAS_PULLUP = 1'b0
) (
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Port configuration.
	input wire port_byte_t direction_in,
	input wire port_byte_t latch_in,
	input wire logic pullup_en_in,
	// Peripheral takeover.
	input wire port_byte_t take_in,
	input wire port_byte_t periph_out_in,
	input wire port_byte_t periph_oe_n_in,
	// Pad side.
	output port_byte_t pin_out_out,
	output port_byte_t pin_oe_n_out,
	output port_byte_t pullup_out
);

	port_byte_t input_mode;
	port_byte_t pull_mask;

	// A pin counts as an input when its owner has released the driver.
	assign input_mode = (take_in & periph_oe_n_in) | (~take_in & direction_in);
	assign pull_mask = {`PORT_WIDTH{HAS_PULLUP & pullup_en_in}};

	// Driver select is registered so every pad signal comes straight from a flop.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			pin_out_out <= `LATCH_RESET;
			pin_oe_n_out <= `DIRECTION_RESET;
		end else begin
			pin_out_out <= (take_in & periph_out_in) | (~take_in & latch_in);
			pin_oe_n_out <= input_mode;
		end
	end

	// The pull-up is dropped while driving so it never fights the output stage.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			pullup_out <= 8'h00;
		end else begin
			pullup_out <= pull_mask & input_mode;
		end
	end

endmodule

// File: verilog/general_purpose_io_port.sv
// Register bank and pad control for nine general purpose I/O ports.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`include "gpio_regs.svh"

module general_purpose_io_port
	import gpio_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Register port.
	input wire logic [`ADDR_WIDTH-1:0] addr_in,
	input wire port_byte_t wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output port_byte_t rd_data_out,
	// Pads, port A in bits 7:0 up to port J in bits 71:64.
	input wire logic [`PIN_COUNT-1:0] pin_in,
	output logic [`PIN_COUNT-1:0] pin_out_out,
	output logic [`PIN_COUNT-1:0] pin_oe_n_out,
	output logic [`PIN_COUNT-1:0] pin_pullup_out,
	// Peripheral takeover, one bit per pin.
	input wire logic [`PIN_COUNT-1:0] periph_take_in,
	input wire logic [`PIN_COUNT-1:0] periph_out_in,
	input wire logic [`PIN_COUNT-1:0] periph_oe_n_in
);

	port_byte_t direction_register [`NUM_PORTS];
	port_byte_t output_latch_register [`NUM_PORTS];
	logic port_b_pullup_control;
	logic port_d_pullup_control;
	logic port_e_pullup_control;
	logic port_j_pullup_control;
	logic [`NUM_PORTS-1:0] pullup_en;
	reg_kind_e wr_kind;
	reg_kind_e rd_kind;
	logic [3:0] wr_port;
	logic [3:0] rd_port;
	port_byte_t rd_next;

	// Word index decode; misaligned or out-of-map addresses select nothing.
	function automatic reg_kind_e kind_of(input logic [`ADDR_WIDTH-1:0] a);
		logic [5:0] idx;
		logic [5:0] sel;
		begin
			idx = a[7:2];
			sel = idx % `REGS_PER_PORT;
			if (a[1:0] != 2'h0) begin
				kind_of = REG_NONE;
			end else if (idx < `PORT_REG_COUNT) begin
				if (sel == `SEL_DIRECTION) begin
					kind_of = REG_DIRECTION;
				end else if (sel == `SEL_LEVEL) begin
					kind_of = REG_LEVEL;
				end else begin
					kind_of = REG_LATCH;
				end
			end else if (idx == `INTERRUPT_CONTROL_TWO_INDEX) begin
				kind_of = REG_PULLUP;
			end else begin
				kind_of = REG_NONE;
			end
		end
	endfunction

	// Port number of a port register address.
	function automatic logic [3:0] port_of(input logic [`ADDR_WIDTH-1:0] a);
		logic [5:0] q;
		begin
			q = a[7:2] / `REGS_PER_PORT;
			port_of = q[3:0];
		end
	endfunction

	assign wr_kind = kind_of(addr_in);
	assign rd_kind = kind_of(addr_in);
	assign wr_port = port_of(addr_in);
	assign rd_port = port_of(addr_in);

	// Port order A B C D E F G H J; only B, D, E and J carry pull-ups.
	assign pullup_en = {port_j_pullup_control, 3'h0, port_e_pullup_control, port_d_pullup_control, 1'b0,
		port_b_pullup_control, 1'b0};

	// Direction registers come up all ones so no pin drives before software asks.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			for (int p = 0; p < `NUM_PORTS; p++) begin
				direction_register[p] <= `DIRECTION_RESET;
			end
		end else if (wr_en_in && wr_kind == REG_DIRECTION) begin
			for (int p = 0; p < `NUM_PORTS; p++) begin
				if (wr_port == 4'(p)) begin
					direction_register[p] <= wr_data_in;
				end
			end
		end
	end

	// Both the level address and the latch address land in the one latch.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			for (int p = 0; p < `NUM_PORTS; p++) begin
				output_latch_register[p] <= `LATCH_RESET;
			end
		end else if (wr_en_in && (wr_kind == REG_LEVEL || wr_kind == REG_LATCH)) begin
			for (int p = 0; p < `NUM_PORTS; p++) begin
				if (wr_port == 4'(p)) begin
					output_latch_register[p] <= wr_data_in;
				end
			end
		end
	end

	// Pull-up controls: B in the interrupt control word, D/E/J in the port G level word.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			port_b_pullup_control <= 1'b0;
			port_d_pullup_control <= 1'b0;
			port_e_pullup_control <= 1'b0;
			port_j_pullup_control <= 1'b0;
		end else if (wr_en_in) begin
			if (wr_kind == REG_PULLUP) begin
				port_b_pullup_control <= wr_data_in[`PULLUP_B_BIT];
			end else if (wr_kind == REG_LEVEL && wr_port == `PORT_G_INDEX) begin
				port_d_pullup_control <= wr_data_in[`PULLUP_D_BIT];
				port_e_pullup_control <= wr_data_in[`PULLUP_E_BIT];
				port_j_pullup_control <= wr_data_in[`PULLUP_J_BIT];
			end
		end
	end

	// Read mux; unused control bits and unmapped addresses read as zero.
	always_comb begin
		rd_next = 8'h00;
		for (int p = 0; p < `NUM_PORTS; p++) begin
			if (rd_port == 4'(p)) begin
				if (rd_kind == REG_DIRECTION) begin
					rd_next = direction_register[p];
				end else if (rd_kind == REG_LEVEL) begin
					rd_next = pin_in[p*`PORT_WIDTH +: `PORT_WIDTH];
				end else if (rd_kind == REG_LATCH) begin
					rd_next = output_latch_register[p];
				end
			end
		end
		if (rd_kind == REG_LEVEL && rd_port == `PORT_G_INDEX) begin
			rd_next[`PULLUP_D_BIT] = port_d_pullup_control;
			rd_next[`PULLUP_E_BIT] = port_e_pullup_control;
			rd_next[`PULLUP_J_BIT] = port_j_pullup_control;
		end
		if (rd_kind == REG_PULLUP) begin
			rd_next[`PULLUP_B_BIT] = port_b_pullup_control;
		end
	end

	// Read data stands only in the cycle after the strobe and is zero otherwise.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			rd_data_out <= 8'h00;
		end else if (rd_en_in) begin
			rd_data_out <= rd_next;
		end else begin
			rd_data_out <= 8'h00;
		end
	end

	// One pad slice per port; the pull-up hardware exists only where the port has it.
	for (genvar g = 0; g < `NUM_PORTS; g++) begin : g_port
		gpio_pin_slice #(
			.HAS_PULLUP(g == 1 || g == 3 || g == 4 || g == 8)
		) u_slice (
			.sys_clk_in(sys_clk_in),
			.rst_n_in(rst_n_in),
			.direction_in(direction_register[g]),
			.latch_in(output_latch_register[g]),
			.pullup_en_in(pullup_en[g]),
			.take_in(periph_take_in[g*`PORT_WIDTH +: `PORT_WIDTH]),
			.periph_out_in(periph_out_in[g*`PORT_WIDTH +: `PORT_WIDTH]),
			.periph_oe_n_in(periph_oe_n_in[g*`PORT_WIDTH +: `PORT_WIDTH]),
			.pin_out_out(pin_out_out[g*`PORT_WIDTH +: `PORT_WIDTH]),
			.pin_oe_n_out(pin_oe_n_out[g*`PORT_WIDTH +: `PORT_WIDTH]),
			.pullup_out(pin_pullup_out[g*`PORT_WIDTH +: `PORT_WIDTH])
		);
	end

	// Checks on port A pin 0 and port B pin 0 stand for every pin of the bank.
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	AST_DIR_ONE_RELEASES: assert property (
		(wr_en_in && wr_kind == REG_DIRECTION && wr_port == 4'h0 && wr_data_in[0]) ##1 !periph_take_in[0]
		|=> pin_oe_n_out[0])
		else $error("pin stays driven after its direction bit was set");

	AST_DIR_ZERO_DRIVES: assert property (
		(wr_en_in && wr_kind == REG_DIRECTION && wr_port == 4'h0 && !wr_data_in[0]) ##1 !periph_take_in[0]
		|=> !pin_oe_n_out[0] && pin_out_out[0] == $past(output_latch_register[0][0]))
		else $error("pin does not drive its latch bit after direction cleared");

	AST_LEVEL_READS_PINS: assert property (
		rd_en_in && rd_kind == REG_LEVEL && rd_port == 4'h0 |=> rd_data_out == $past(pin_in[7:0]))
		else $error("level read does not return pin levels");

	AST_LEVEL_WRITE_HITS_LATCH: assert property (
		wr_en_in && wr_kind == REG_LEVEL && wr_port == 4'h0
		|=> output_latch_register[0] == $past(wr_data_in) ##1 pin_out_out[0] == $past(wr_data_in[0], 2)
			|| $past(periph_take_in[0]))
		else $error("level write did not reach the latch");

	AST_LATCH_READBACK: assert property (
		rd_en_in && rd_kind == REG_LATCH && rd_port == 4'h0 |=> rd_data_out == $past(output_latch_register[0]))
		else $error("latch read does not return the stored value");

	AST_TAKEOVER: assert property (
		periph_take_in[0] |=> pin_out_out[0] == $past(periph_out_in[0]) && pin_oe_n_out[0] == $past(periph_oe_n_in[0]))
		else $error("peripheral did not get the pin");

	AST_NO_PULLUP_PORT_A: assert property (
		pin_pullup_out[7:0] == 8'h00)
		else $error("pull-up seen on a port without one");

	AST_PULLUP_B_WRITE: assert property (
		wr_en_in && wr_kind == REG_PULLUP |=> port_b_pullup_control == $past(wr_data_in[7]))
		else $error("port B pull-up bit not taken from bit 7");

	AST_PULLUP_ONLY_INPUT: assert property (
		pin_pullup_out[8] |-> $past(port_b_pullup_control) && ($past(periph_take_in[8]) || $past(direction_register[1][0])))
		else $error("pull-up on a pin that is not an input");

	AST_RESET_STATE: assert property (@(posedge sys_clk_in) disable iff (1'b0)
		!rst_n_in |=> direction_register[0] == `DIRECTION_RESET && !port_b_pullup_control && !port_j_pullup_control)
		else $error("reset state is not released inputs without pull-ups");

	COV_DRIVE_OUT: cover property (wr_en_in && wr_kind == REG_DIRECTION ##2 !pin_oe_n_out[0]);
	COV_LEVEL_READ: cover property (rd_en_in && rd_kind == REG_LEVEL ##1 rd_data_out != 8'h00);
	COV_TAKEOVER: cover property (periph_take_in[0] ##1 periph_take_in[0]);
	COV_PULLUP_ON: cover property (pin_pullup_out[8]);

endmodule

// File: verification/pin_partner.sv
// Pads and the outside logic wired to them, resolved to the levels the port bank sees.
`timescale 1ns/10ps
`include "gpio_regs.svh"

module pin_partner (
	// Clock.
	input wire logic sys_clk_in,
	// Pad controls from the port bank.
	input wire logic [`PIN_COUNT-1:0] pin_out_in,
	input wire logic [`PIN_COUNT-1:0] pin_oe_n_in,
	input wire logic [`PIN_COUNT-1:0] pin_pullup_in,
	// Outside drivers and board resistors.
	input wire logic [`PIN_COUNT-1:0] ext_drive_in,
	input wire logic [`PIN_COUNT-1:0] ext_val_in,
	input wire logic [`PIN_COUNT-1:0] ext_pullup_in,
	// Resolved line levels.
	output logic [`PIN_COUNT-1:0] pin_level_out
);
	logic float_reg = 1'b0;

	// A line nobody holds flips every cycle, so a stale value is never mistaken for a level.
	always @(posedge sys_clk_in) begin
		float_reg <= ~float_reg;
	end

	// The port's own driver wins, then outside drivers, then any pull-up.
	always_comb begin
		for (int i = 0; i < `PIN_COUNT; i++) begin
			if (!pin_oe_n_in[i])
				pin_level_out[i] = pin_out_in[i];
			else if (ext_drive_in[i])
				pin_level_out[i] = ext_val_in[i];
			else if (ext_pullup_in[i] || pin_pullup_in[i])
				pin_level_out[i] = 1'b1;
			else
				pin_level_out[i] = float_reg;
		end
	end
endmodule

// File: verification/general_purpose_io_port_tb.sv
// Self-checking bench for the nine-port general purpose I/O bank.
`timescale 1ns/10ps
`include "gpio_regs.svh"

module general_purpose_io_port_tb
	import gpio_pkg::*;
;
	typedef logic [`PIN_COUNT-1:0] pins_t;
	typedef struct {port_byte_t dir; port_byte_t lat; port_byte_t ext; port_byte_t lvl;} row_s;

	logic sys_clk_in, rst_n_in, wr_en_in, rd_en_in;
	logic [7:0] addr_in;
	port_byte_t wr_data_in, rd_data_out;
	pins_t pin_in, pin_out_out, pin_oe_n_out, pin_pullup_out, take, p_out, p_oe_n, ext_drv, ext_val, ext_pu;
	int errors = 0;
	int n_tests = 0;
	// Low nibble is input, so the level shows outside data there and the latch above.
	row_s rows [9] = '{'{8'h0f, 8'h3c, 8'hc3, 8'h33}, '{8'h0f, 8'h5a, 8'ha5, 8'h55},
		'{8'h0f, 8'h96, 8'h69, 8'h99}, '{8'h0f, 8'he1, 8'h1e, 8'hee}, '{8'h0f, 8'h0f, 8'hf0, 8'h00},
		'{8'h0f, 8'h78, 8'h87, 8'h77}, '{8'h0f, 8'ha5, 8'h5a, 8'haa}, '{8'h0f, 8'hc3, 8'h3c, 8'hcc},
		'{8'h0f, 8'h69, 8'h96, 8'h66}};

	general_purpose_io_port u_general_purpose_io_port (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
		.rd_data_out(rd_data_out), .pin_in(pin_in), .pin_out_out(pin_out_out), .pin_oe_n_out(pin_oe_n_out),
		.pin_pullup_out(pin_pullup_out), .periph_take_in(take), .periph_out_in(p_out), .periph_oe_n_in(p_oe_n));

	pin_partner u_pin_partner (.sys_clk_in(sys_clk_in), .pin_out_in(pin_out_out), .pin_oe_n_in(pin_oe_n_out),
		.pin_pullup_in(pin_pullup_out), .ext_drive_in(ext_drv), .ext_val_in(ext_val), .ext_pullup_in(ext_pu),
		.pin_level_out(pin_in));

	// Free-running 100 MHz clock.
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	task automatic chk(input string nm, input pins_t seen, input pins_t exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input port_byte_t d);
		@(posedge sys_clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		@(posedge sys_clk_in);
		wr_en_in <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are sampled there.
	task automatic rd(input logic [7:0] a, input port_byte_t e);
		@(posedge sys_clk_in);
		addr_in <= a;
		rd_en_in <= 1'b1;
		@(posedge sys_clk_in);
		rd_en_in <= 1'b0;
		#1;
		chk("rd_data", rd_data_out, e);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Hang guard, well beyond the roughly 150 cycles the sequence needs.
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		errors++;
		tally_and_finish();
	end

	// Main sequence: reset, the table of ports, then hand-written cases.
	initial begin
		{rst_n_in, wr_en_in, rd_en_in, addr_in, wr_data_in} = '0;
		{take, p_out, p_oe_n, ext_val, ext_pu} = '0;
		ext_drv = '1;
		repeat (3) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		tick(1);
		chk("oe_n_reset", pin_oe_n_out, '1);
		chk("pullup_reset", pin_pullup_out, '0);
		rd(8'h0c, `DIRECTION_RESET);
		for (int p = 0; p < 9; p++) begin
			ext_val[p*8+:8] <= rows[p].ext;
			wr(8'(p * 12), rows[p].dir);
			wr(8'(p * 12 + 4), rows[p].lat);
			tick(2);
			chk("oe_n", pin_oe_n_out[p*8+:8], rows[p].dir);
			chk("drive", pin_out_out[p*8+:8] & ~rows[p].dir, rows[p].lat & ~rows[p].dir);
			rd(8'(p * 12 + 8), rows[p].lat);
			rd(8'(p * 12 + 4), rows[p].lvl);
		end
		// Port B pull-up on; D and J were enabled by the port G level write in the table.
		ext_drv[31:8] <= '0;
		wr(8'h6c, 8'h80);
		tick(2);
		// Only the low nibble is input, so only those pins may carry a pull-up.
		chk("pullup_b", pin_pullup_out[15:8], 8'h0f);
		chk("pullup_d", pin_pullup_out[31:24], 8'h0f);
		chk("pullup_e", pin_pullup_out[39:32], 8'h00);
		chk("pullup_a", pin_pullup_out[7:0], 8'h00);
		rd(8'h6c, 8'h80);
		rd(8'h10, 8'h5f);
		// Signalling through an outside pull-up: latch low, then only direction moves.
		ext_pu[31] <= 1'b1;
		wr(8'h2c, 8'h00);
		tick(2);
		rd(8'h28, 8'h0f);
		wr(8'h24, 8'h8f);
		tick(2);
		rd(8'h28, 8'h8f);
		// Port G level write turns E on and D, J off, and writes the whole port G latch.
		wr(8'h4c, 8'h40);
		tick(2);
		chk("pullup_e_on", pin_pullup_out[39:32], 8'h0f);
		chk("pullup_d_off", pin_pullup_out[31:24], 8'h00);
		chk("pullup_j_off", pin_pullup_out[71:64], 8'h00);
		rd(8'h4c, 8'h4a);
		// Port A pin 0 turns into an output and follows a latch write.
		wr(8'h00, 8'h0e);
		wr(8'h08, 8'h3d);
		tick(2);
		chk("a0_oe_n", pin_oe_n_out[0], 1'b0);
		chk("a0_out", pin_out_out[0], 1'b1);
		rd(8'h08, 8'h3d);
		// Peripheral drives pin A0 low and releases pin B5, whose latch bit is zero.
		@(posedge sys_clk_in);
		take[0] <= 1'b1;
		p_out[0] <= 1'b0;
		take[13] <= 1'b1;
		p_oe_n[13] <= 1'b1;
		tick(2);
		chk("take_oe_n", pin_oe_n_out[0], 1'b0);
		chk("take_out", pin_out_out[0], 1'b0);
		chk("take_release", pin_oe_n_out[13], 1'b1);
		chk("take_pullup", pin_pullup_out[13], 1'b1);
		rd(8'h10, 8'h7f);
		@(posedge sys_clk_in);
		{take, p_oe_n} <= '0;
		// Unmapped and misaligned places read zero and ignore writes.
		wr(8'h70, 8'hff);
		rd(8'h70, 8'h00);
		rd(8'h01, 8'h00);
		tick(1);
		chk("rd_idle", rd_data_out, 8'h00);
		// Second reset in mid-run, driven on clock edges like every other input.
		@(posedge sys_clk_in);
		rst_n_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		tick(1);
		chk("oe_n_rst2", pin_oe_n_out, '1);
		chk("pullup_rst2", pin_pullup_out, '0);
		chk("out_rst2", pin_out_out, '0);
		rd(8'h6c, 8'h00);
		rd(8'h00, `DIRECTION_RESET);
		rd(8'h08, `LATCH_RESET);
		tally_and_finish();
	end
endmodule
